// >>> pkg/opdec_regs.vh
// constants for the first-byte opcode decoder
// Functional notes
// - 01DDDSSS with neither DDD nor SSS 110 copies register SSS into DDD, 5 cycles.
// - 01110SSS stores register SSS into memory operand, 7 cycles.
// - 01DDD110 loads memory operand into register DDD, 7 cycles.
// - 10000SSS add, 10001SSS add with carry, register to accumulator, 4 cycles.
// - 10010SSS subtract, 10011SSS subtract with borrow, 4 cycles.
// - 10100/10101/10110SSS and, exclusive or, inclusive or, 4 cycles.
// - 10111SSS compares register SSS with accumulator, 4 cycles.
// - 10000110 add memory, 10001110 add memory with carry, 7 cycles.
// - 10010110 subtracts memory operand from accumulator, 7 cycles.
// - 11CCC000 conditional return on condition CCC except 010/011, 5 or 11 cycles.
// - 00PP0001 loads 16-bit immediate into pair PP, 10 cycles.
// - 11PP0101 pushes pair PP (B-C, D-E, H-L) on stack, 11 cycles.
`ifndef OPDEC_REGS_VH
`define OPDEC_REGS_VH
// operation classes
`define OP_UNKNOWN            5'h00
`define OP_COPY_REGISTER      5'h01
`define OP_STORE_MEM          5'h02
`define OP_LOAD_MEM           5'h03
`define OP_HALT               5'h04
`define OP_ADD                5'h05
`define OP_ADD_CARRY          5'h06
`define OP_SUB                5'h07
`define OP_MINUS_WITH_BORROW  5'h08
`define OP_BITWISE_AND        5'h09
`define OP_EXCLUSIVE_OR       5'h0a
`define OP_INCLUSIVE_OR       5'h0b
`define OP_COMPARE            5'h0c
`define OP_RETURN_COND        5'h0d
`define OP_LOAD_PAIR_IMM      5'h0e
`define OP_PUSH_PAIR          5'h0f
// register field codes
`define REG_B                 3'h0
`define REG_C                 3'h1
`define REG_D                 3'h2
`define REG_E                 3'h3
`define REG_H                 3'h4
`define REG_L                 3'h5
`define REG_MEM               3'h6
`define REG_ACC               3'h7
// return conditions
`define COND_NONZERO          3'h0
`define COND_ZERO             3'h1
`define COND_ODD_PARITY       3'h4
`define COND_EVEN_PARITY      3'h5
`define COND_POSITIVE         3'h6
`define COND_MINUS            3'h7
// halt opcode
`define HALT_CODE             8'h76
// cycle counts
`define CYC_NONE              4'h0
`define CYC_ALU_REG           4'h4
`define CYC_COPY              4'h5
`define CYC_MEM               4'h7
`define CYC_LOAD_PAIR         4'ha
`define CYC_PUSH              4'hb
`define CYC_RET_SKIP          4'h5
`define CYC_RET_TAKEN         4'hb
`endif

// >>> rtl/ret_cycles.v
// cycle count of a conditional return from its condition and the flags
`timescale 1ns/1ps
`include "opdec_regs.vh"
module ret_cycles (
   // condition and flags
   input  wire [2:0] cond,
   input  wire       flag_zero,
   input  wire       flag_sign,
   input  wire       flag_parity,
   // result
   output reg        taken,
   output reg  [3:0] cycles
);
   always @* begin
      case (cond)
         `COND_NONZERO:     taken = ~flag_zero;
         `COND_ZERO:        taken = flag_zero;
         `COND_ODD_PARITY:  taken = ~flag_parity;
         `COND_EVEN_PARITY: taken = flag_parity;
         `COND_POSITIVE:    taken = ~flag_sign;
         `COND_MINUS:       taken = flag_sign;
         default:           taken = 1'b0;
      endcase
      cycles = taken ? `CYC_RET_TAKEN : `CYC_RET_SKIP;
   end
endmodule // ret_cycles

// >>> rtl/opcode_decoder.v
// first-byte opcode decoder feeding the execution sequencer
`timescale 1ns/1ps
`include "opdec_regs.vh"
module opcode_decoder (
   // clock and reset
   input  wire       core_clk,
   input  wire       rst_n,
   // opcode byte from program memory, same clock domain
   input  wire       op_valid,
   input  wire [7:0] op_byte,
   // flags from the execution unit
   input  wire       flag_zero,
   input  wire       flag_sign,
   input  wire       flag_parity,
   // decoded result
   output reg        dec_valid_q,
   output reg  [4:0] dec_class_q,
   output reg  [2:0] dst_reg_q,
   output reg  [2:0] src_reg_q,
   output reg  [1:0] pair_q,
   output reg  [2:0] cond_q,
   output reg        ret_taken_q,
   output reg  [3:0] cycles_q
);
   reg        rst_meta_q;
   reg        rst_sync_n_q;
   reg  [4:0] class_d;
   reg  [3:0] cycles_d;
   wire       ret_taken;
   wire [3:0] ret_cyc;

   // reset release through two flops
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q   <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end else begin
         rst_meta_q   <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   ret_cycles u_ret (
      .cond        (op_byte[5:3]),
      .flag_zero   (flag_zero),
      .flag_sign   (flag_sign),
      .flag_parity (flag_parity),
      .taken       (ret_taken),
      .cycles      (ret_cyc)
   );

   // field of a register operand is memory
   function is_mem;
      input [2:0] f;
      begin
         is_mem = (f == `REG_MEM);
      end
   endfunction

   always @* begin
      class_d  = `OP_UNKNOWN;
      cycles_d = `CYC_NONE;
      if (op_byte == `HALT_CODE) begin
         class_d  = `OP_HALT;
         cycles_d = `CYC_MEM;
      end else if (op_byte[7:6] == 2'b01) begin
         if (is_mem(op_byte[5:3])) begin
            class_d  = `OP_STORE_MEM;
            cycles_d = `CYC_MEM;
         end else if (is_mem(op_byte[2:0])) begin
            class_d  = `OP_LOAD_MEM;
            cycles_d = `CYC_MEM;
         end else begin
            class_d  = `OP_COPY_REGISTER;
            cycles_d = `CYC_COPY;
         end
      end else if (op_byte[7:6] == 2'b10) begin
         case (op_byte[5:3])
            3'h0:    class_d = `OP_ADD;
            3'h1:    class_d = `OP_ADD_CARRY;
            3'h2:    class_d = `OP_SUB;
            3'h3:    class_d = `OP_MINUS_WITH_BORROW;
            3'h4:    class_d = `OP_BITWISE_AND;
            3'h5:    class_d = `OP_EXCLUSIVE_OR;
            3'h6:    class_d = `OP_INCLUSIVE_OR;
            default: class_d = `OP_COMPARE;
         endcase
         cycles_d = is_mem(op_byte[2:0]) ? `CYC_MEM : `CYC_ALU_REG;
      end else if (op_byte[7:6] == 2'b11) begin
         // conditional return
         // conditions 010 and 011 stay unknown: outside this decode
         if (op_byte[2:0] == 3'h0 && op_byte[5:4] != 2'b01) begin
            class_d  = `OP_RETURN_COND;
            cycles_d = ret_cyc;
         // push of B-C, D-E, H-L only
         end else if (op_byte[3:0] == 4'h5 && op_byte[5:4] != 2'b11) begin
            class_d  = `OP_PUSH_PAIR;
            cycles_d = `CYC_PUSH;
         end
      end else if (op_byte[3:0] == 4'h1) begin
         // immediate pair load; operands follow in memory
         class_d  = `OP_LOAD_PAIR_IMM;
         cycles_d = `CYC_LOAD_PAIR;
      end
   end

   always @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         dec_valid_q <= 1'b0;
         dec_class_q <= `OP_UNKNOWN;
         dst_reg_q   <= `REG_B;
         src_reg_q   <= `REG_B;
         pair_q      <= 2'h0;
         cond_q      <= 3'h0;
         ret_taken_q <= 1'b0;
         cycles_q    <= `CYC_NONE;
      end else begin
         dec_valid_q <= op_valid;
         // hold last decode so the sequencer sees stable fields
         if (op_valid) begin
            dec_class_q <= class_d;
            dst_reg_q   <= op_byte[5:3];
            src_reg_q   <= op_byte[2:0];
            pair_q      <= op_byte[5:4];
            cond_q      <= op_byte[5:3];
            ret_taken_q <= ret_taken & (class_d == `OP_RETURN_COND);
            cycles_q    <= cycles_d;
         end
      end
   end
endmodule // opcode_decoder

// >>> bench/opdec_properties.sv
// port checker for the opcode decoder
`timescale 1ns/1ps
module opdec_chk (
   // clock, reset and inputs
   input wire logic       core_clk, rst_n, op_valid, flag_zero, flag_sign, flag_parity,
   input wire logic [7:0] op_byte,
   // decoded outputs
   input wire logic       dec_valid_q, ret_taken_q,
   input wire logic [4:0] dec_class_q,
   input wire logic [2:0] dst_reg_q, src_reg_q, cond_q,
   input wire logic [1:0] pair_q,
   input wire logic [3:0] cycles_q
);
   wire [2:0] hi = op_byte[5:3];
   wire [2:0] lo = op_byte[2:0];
   wire [7:0] hold = {flag_sign, ~flag_sign, flag_parity, ~flag_parity, 2'h0, flag_zero, ~flag_zero};
   wire       tk = hold[hi];
   wire       is_ret = op_valid && op_byte[7:6] == 2'h3 && lo == 3'h0 && op_byte[5:4] != 2'h1;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   copy_five_a:
   assert property (op_valid && op_byte[7:6] == 2'h1 && hi != 3'h6 && lo != 3'h6 |=> dec_valid_q &&
      dec_class_q == 5'h01 && cycles_q == 4'h5 && dst_reg_q == $past(hi)) else $error("copy decode wrong");
   mem_move_a:
   assert property (op_valid && op_byte[7:6] == 2'h1 && op_byte != 8'h76 && (hi == 3'h6 || lo == 3'h6) |=>
      cycles_q == 4'h7 && dec_class_q == ($past(hi) == 3'h6 ? 5'h02 : 5'h03)) else $error("memory move wrong");
   halt_wins_a:
   assert property (op_valid && op_byte == 8'h76 |=> dec_class_q == 5'h04 && cycles_q == 4'h7)
      else $error("halt decode wrong");
   alu_class_a:
   assert property (op_valid && op_byte[7:6] == 2'h2 |=> dec_class_q == 5'h05 + $past(hi) &&
      src_reg_q == $past(lo)) else $error("alu class wrong");
   alu_cycles_a:
   assert property (op_valid && op_byte[7:6] == 2'h2 |=> cycles_q == ($past(lo) == 3'h6 ? 4'h7 : 4'h4))
      else $error("alu cycles wrong");
   ret_time_a:
   assert property (is_ret |=> dec_class_q == 5'h0d && cycles_q == ($past(tk) ? 4'hb : 4'h5))
      else $error("return cycles wrong");
   ret_take_a:
   assert property (is_ret |=> ret_taken_q == $past(tk) && cond_q == $past(hi)) else $error("return taken wrong");
   pair_load_a:
   assert property (op_valid && op_byte[7:6] == 2'h0 && op_byte[3:0] == 4'h1 |=> dec_class_q == 5'h0e &&
      cycles_q == 4'ha && pair_q == $past(op_byte[5:4])) else $error("pair load wrong");
   push_pair_a:
   assert property (op_valid && op_byte[7:6] == 2'h3 && op_byte[3:0] == 4'h5 && op_byte[5:4] != 2'h3 |=>
      dec_valid_q && dec_class_q == 5'h0f && cycles_q == 4'hb && pair_q == $past(op_byte[5:4]))
      else $error("push decode wrong");
endmodule // opdec_chk
bind opcode_decoder opdec_chk u_chk (.*);

// >>> bench/prog_mem.sv
// program memory model feeding opcode bytes
`timescale 1ns/1ps
module prog_mem (
   input  wire logic       core_clk,
   input  wire logic       run,
   output logic            op_valid,
   output logic [7:0]      op_byte
);
   logic [7:0] mem [0:7];
   logic [2:0] pc;
   logic [1:0] opnd;
   initial begin
      mem = '{8'h01, 8'h34, 8'h12, 8'h41, 8'hc5, 8'h31, 8'hcd, 8'hab};
      pc = 3'h0;
      opnd = 2'h0;
      op_valid = 1'b0;
      op_byte = 8'h00;
   end
   always @(negedge core_clk) begin
      if (run) begin
         op_valid <= (opnd == 2'h0);
         op_byte <= mem[pc];
         opnd <= (opnd != 2'h0) ? opnd - 2'h1 : ((mem[pc][7:6] == 2'h0 && mem[pc][3:0] == 4'h1) ? 2'h2 : 2'h0);
         pc <= pc + 3'h1;
      end else begin
         op_valid <= 1'b0;
         // drive the inverted last byte, no stale value
         op_byte <= ~op_byte;
      end
   end
endmodule // prog_mem

// >>> bench/tb.sv
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0, rst_n = 1'b0, b_valid = 1'b0, run = 1'b0;
   logic flag_zero = 1'b0, flag_sign = 1'b0, flag_parity = 1'b0, m_valid, dec_valid_q, ret_taken_q;
   logic [7:0] b_byte = 8'h00, m_byte;
   logic [4:0] dec_class_q;
   logic [2:0] dst_reg_q, src_reg_q, cond_q;
   logic [1:0] pair_q;
   logic [3:0] cycles_q;
   int mismatches = 0, compares = 0, n;
   wire logic op_valid = b_valid | m_valid;
   wire logic [7:0] op_byte = b_valid ? b_byte : m_byte;
   opcode_decoder DUT (.*);
   prog_mem u_mem (.core_clk(core_clk), .run(run), .op_valid(m_valid), .op_byte(m_byte));
   initial forever #20 core_clk = ~core_clk;
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic step(input logic [7:0] b, input logic [2:0] f);
      {flag_sign, flag_parity, flag_zero} = f;
      b_valid = 1'b1;
      b_byte = b;
      @(negedge core_clk);
   endtask
   task automatic t_moves;
      for (int i = 'h40; i < 'h80; i++) begin
         step(i[7:0], 3'h0);
         chk("class", (i == 'h76) ? 4 : (i[5:3] == 6) ? 2 : (i[2:0] == 6) ? 3 : 1, dec_class_q);
         chk("cycles", (i[5:3] == 6 || i[2:0] == 6) ? 7 : 5, cycles_q);
         chk("regs", {i[5:3], i[2:0]}, {dst_reg_q, src_reg_q});
      end
      b_valid = 1'b0;
      @(negedge core_clk);
      $display("moves done");
   endtask
   task automatic t_alu;
      for (int i = 'h80; i < 'hc0; i++) begin
         step(i[7:0], 3'h0);
         chk("class", 5 + i[5:3], dec_class_q);
         chk("cycles", (i[2:0] == 6) ? 7 : 4, cycles_q);
      end
      b_valid = 1'b0;
      @(negedge core_clk);
      $display("alu done");
   endtask
   task automatic t_ret;
      logic [7:0] tv;
      for (int c = 0; c < 8; c++) begin
         if (c == 2 || c == 3) continue;
         for (int f = 0; f < 8; f++) begin
            step({2'h3, c[2:0], 3'h0}, f[2:0]);
            tv = {f[2], ~f[2], f[1], ~f[1], 2'h0, f[0], ~f[0]};
            chk("taken", tv[c], ret_taken_q);
            chk("cycles", tv[c] ? 11 : 5, cycles_q);
            chk("cond", c, cond_q);
         end
      end
      b_valid = 1'b0;
      @(negedge core_clk);
      $display("returns done");
   endtask
   task automatic t_pairs;
      for (int p = 0; p < 4; p++) begin
         step({2'h0, p[1:0], 4'h1}, 3'h0);
         chk("load", {p[1:0], 4'ha}, {pair_q, cycles_q});
         if (p == 3) continue;
         step({2'h3, p[1:0], 4'h5}, 3'h0);
         chk("push", {p[1:0], 4'hb}, {pair_q, cycles_q});
      end
      b_valid = 1'b0;
      @(negedge core_clk);
      $display("pairs done");
   endtask
   task automatic t_prog;
      run <= 1'b1;
      n = 0;
      for (int i = 0; i < 11; i++) begin
         @(negedge core_clk);
         if (i == 7) run <= 1'b0;
         n += dec_valid_q;
      end
      chk("pulses", 8'h04, n[7:0]);
      chk("last", 8'h3a, {pair_q, cycles_q});
      $display("program done");
   endtask
   task tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      t_moves();
      t_alu();
      t_ret();
      t_pairs();
      t_prog();
      tally_and_finish();
   end
endmodule // tb
